// ===== rtl/lke_map.svh
`ifndef LKE_MAP_SVH
`define LKE_MAP_SVH

// Register byte offsets on the APB side.
`define LKE_OFF_CTRL        12'h100
`define LKE_OFF_INPUT       12'h104
`define LKE_OFF_OUTPUT      12'h108
`define LKE_OFF_STATUS      12'h10c

// Legacy I/O port addresses seen by application software.
`define LKE_PORT_DATA       16'h0060
`define LKE_PORT_CMD        16'h0064

// Command byte that opens a Gate A20 sequence.
`define LKE_CMD_A20         8'hd1

// Status byte field positions.
`define LKE_ST_PARITY       7
`define LKE_ST_TIMEOUT      6
`define LKE_ST_AUX          5
`define LKE_ST_INHIBIT      4
`define LKE_ST_CMD          3
`define LKE_ST_FLAG         2
`define LKE_ST_INFULL       1
`define LKE_ST_OUTFULL      0

// Control register field positions.
`define LKE_CT_A20STATE     8
`define LKE_CT_IRQ12ACT     7
`define LKE_CT_IRQ1ACT      6
`define LKE_CT_A20SEQ       5
`define LKE_CT_EXTEN        4
`define LKE_CT_IRQGATE      3
`define LKE_CT_CHARWAIT     2
`define LKE_CT_EMULIRQ      1
`define LKE_CT_EMULON       0

// Reset values.
`define LKE_RST_BYTE        8'h00
`define LKE_RST_WORD        32'h0000_0000

`endif

// ===== rtl/lke_pkg.sv
package lke_pkg;

  // One legacy I/O access from application software, valid for one cycle.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  data;
  } lke_io_req_t;

  // Decoded legacy port events, each a one-cycle pulse.
  typedef struct packed {
    logic       wr_data;
    logic       wr_cmd;
    logic       rd_data;
    logic       rd_cmd;
    logic [7:0] byte_val;
  } lke_io_evt_t;

endpackage

// ===== rtl/lke_flag_cell.sv
`timescale 1ns/10ps
`default_nettype none

// One status or control flag: hardware set, software load, hardware clear.
module lke_flag_cell
  import lke_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic set,
  input  wire logic load,
  input  wire logic load_val,
  input  wire logic clr,
  output var  logic q
);

  logic q_d;

  // A hardware set always wins, so an event never hides behind a write.
  always_comb begin
    if (set) begin
      q_d = 1'b1;
    end else if (load) begin
      q_d = load_val;
    end else if (clr) begin
      q_d = 1'b0;
    end else begin
      q_d = q;
    end
  end

  // State only moves while the clock enable is high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 1'b0;
    end else if (ce) begin
      q <= q_d;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/lke_io_decode.sv
`timescale 1ns/10ps
`default_nettype none

`include "lke_map.svh"

// Turns a raw legacy I/O access into port 60H and 64H pulses.
module lke_io_decode
  import lke_pkg::*;
(
  input  wire logic        emul_on,
  input  wire lke_io_req_t req,
  output wire lke_io_evt_t evt
);

  logic hit_data;
  logic hit_cmd;

  // Nothing is decoded while emulation is off, so the legacy ports stay silent.
  assign hit_data = emul_on & req.valid & (req.addr == `LKE_PORT_DATA);
  assign hit_cmd  = emul_on & req.valid & (req.addr == `LKE_PORT_CMD);

  // Direction split of each decoded access.
  assign evt.wr_data  = hit_data & req.write;
  assign evt.wr_cmd   = hit_cmd & req.write;
  assign evt.rd_data  = hit_data & ~req.write;
  assign evt.rd_cmd   = hit_cmd & ~req.write;
  assign evt.byte_val = req.data;

endmodule

`default_nettype wire

// ===== rtl/lke_emul_top.sv
// Functional notes
// - A read of port 60H returns the output byte, bits 7:0.
// - Status bit 7 reports a parity error on keyboard or mouse data.
// - Status bit 6 reports a time-out to software.
// - IRQ12 is driven when aux full, output full and irq gate are set.
// - Status bit 4 reads one when the keyboard is not inhibited.
// - Write to 60H clears status bit 3; write to 64H sets it.
// - Status bit 2 is a software flag, written and read back.
// - Writes to 60H or 64H set input full, except a 60H write during a Gate A20 sequence.
// - Input full with emulation enabled raises the emulation interrupt condition.
// - A read of port 60H clears output full.
// - Irq gate set and aux full clear drive IRQ1 while output full.
// - Output full clear with char pending set raises the emulation interrupt.
// - Writing D1H to 64H sets the A20 sequence flag; other values clear it.
// - Port decode and all interrupts but the external irq path work only while emulation is enabled.
// - Bytes written to 60H or 64H are captured in the input byte.
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

`include "lke_map.svh"

module lke_emul_top
  import lke_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire lke_io_req_t io_req,
  output var  logic [7:0]  io_rdata,
  input  wire logic        kbd_not_inhibited,
  input  wire logic        a20_state_in,
  input  wire logic        kbc_irq1,
  input  wire logic        kbc_irq12,
  output var  logic        irq1,
  output var  logic        irq12,
  output var  logic        emul_irq
);

  lke_io_evt_t evt;

  logic        apb_setup;
  logic        apb_done;
  logic        wr_ctrl;
  logic        wr_output;
  logic        wr_status;
  logic        addr_hit;
  logic [31:0] rd_mux;

  logic        legacy_emul_on;
  logic        char_wait_flag;
  logic        legacy_irq_gate;
  logic        ext_irq_en;
  logic        a20_seq_active;
  logic        irq1_seen;
  logic        irq12_seen;
  logic        kbc_irq1_q;
  logic        kbc_irq12_q;

  logic        parity_err;
  logic        timeout_flag;
  logic        mouse_byte_flag;
  logic        cmd_data_flag;
  logic        sys_flag;
  logic        in_buf_loaded;
  logic        out_buf_loaded;

  logic [7:0]  emulated_input_byte_q;
  logic [7:0]  emulated_output_byte_q;
  logic [7:0]  emulated_legacy_status;
  logic [31:0] emulation_control_reg;
  logic        emul_cond;
  logic        a20_exempt;

  // Legacy I/O decode; it sees the enable so a disabled block ignores the ports.
  lke_io_decode u_decode (
    .emul_on (legacy_emul_on),
    .req     (io_req),
    .evt     (evt)
  );

  // APB phases. A write takes effect only at the edge that ends the access.
  assign apb_setup = psel & ~penable;
  assign apb_done  = ce & psel & penable & pready;
  assign wr_ctrl   = apb_done & pwrite & (paddr == `LKE_OFF_CTRL);
  assign wr_output = apb_done & pwrite & (paddr == `LKE_OFF_OUTPUT);
  assign wr_status = apb_done & pwrite & (paddr == `LKE_OFF_STATUS);

  // Address decode; anything outside the four words answers with an error.
  assign addr_hit = (paddr == `LKE_OFF_CTRL)   | (paddr == `LKE_OFF_INPUT) |
                    (paddr == `LKE_OFF_OUTPUT) | (paddr == `LKE_OFF_STATUS);

  // A write to 60H while the A20 sequence is open is handled in hardware.
  assign a20_exempt = evt.wr_data & a20_seq_active;

  // Control register fields.

  // Plain software bits of the control word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      legacy_emul_on  <= 1'b0;
      char_wait_flag  <= 1'b0;
      legacy_irq_gate <= 1'b0;
      ext_irq_en      <= 1'b0;
    end else if (ce && wr_ctrl) begin
      legacy_emul_on  <= pwdata[`LKE_CT_EMULON];
      char_wait_flag  <= pwdata[`LKE_CT_CHARWAIT];
      legacy_irq_gate <= pwdata[`LKE_CT_IRQGATE];
      ext_irq_en      <= pwdata[`LKE_CT_EXTEN];
    end
  end

  // The A20 sequence flag only moves on command port writes.
  lke_flag_cell u_a20_seq (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .set      (evt.wr_cmd & (evt.byte_val == `LKE_CMD_A20)),
    .load     (1'b0),
    .load_val (1'b0),
    .clr      (evt.wr_cmd & (evt.byte_val != `LKE_CMD_A20)),
    .q        (a20_seq_active)
  );

  // Previous levels of the keyboard controller interrupts for edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kbc_irq1_q  <= 1'b0;
      kbc_irq12_q <= 1'b0;
    end else if (ce) begin
      kbc_irq1_q  <= kbc_irq1;
      kbc_irq12_q <= kbc_irq12;
    end
  end

  // Rising edges are caught and held; software writes one to clear them.
  lke_flag_cell u_irq1_seen (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .set      (kbc_irq1 & ~kbc_irq1_q),
    .load     (1'b0),
    .load_val (1'b0),
    .clr      (wr_ctrl & pwdata[`LKE_CT_IRQ1ACT]),
    .q        (irq1_seen)
  );

  lke_flag_cell u_irq12_seen (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .set      (kbc_irq12 & ~kbc_irq12_q),
    .load     (1'b0),
    .load_val (1'b0),
    .clr      (wr_ctrl & pwdata[`LKE_CT_IRQ12ACT]),
    .q        (irq12_seen)
  );

  // Status byte fields.

  // Parity, time-out, aux full and the system flag are software owned.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_err      <= 1'b0;
      timeout_flag    <= 1'b0;
      mouse_byte_flag <= 1'b0;
      sys_flag        <= 1'b0;
    end else if (ce && wr_status) begin
      parity_err      <= pwdata[`LKE_ST_PARITY];
      timeout_flag    <= pwdata[`LKE_ST_TIMEOUT];
      mouse_byte_flag <= pwdata[`LKE_ST_AUX];
      sys_flag        <= pwdata[`LKE_ST_FLAG];
    end
  end

  // Command or data indicator follows the last legacy port written.
  lke_flag_cell u_cmd_data (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .set      (evt.wr_cmd),
    .load     (wr_status & ~evt.wr_data),
    .load_val (pwdata[`LKE_ST_CMD]),
    .clr      (evt.wr_data),
    .q        (cmd_data_flag)
  );

  // Input full: a port write sets it and beats a clearing software write.
  lke_flag_cell u_in_full (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .set      ((evt.wr_data | evt.wr_cmd) & ~a20_exempt),
    .load     (wr_status),
    .load_val (pwdata[`LKE_ST_INFULL]),
    .clr      (1'b0),
    .q        (in_buf_loaded)
  );

  // Output full: software loads it with a new byte, a port 60H read clears it.
  // A software load in the same cycle as the read wins, since it is fresh data.
  lke_flag_cell u_out_full (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .set      (1'b0),
    .load     (wr_status),
    .load_val (pwdata[`LKE_ST_OUTFULL]),
    .clr      (evt.rd_data),
    .q        (out_buf_loaded)
  );

  // Assembled status byte; bit 4 is a live view of the inhibit switch.
  assign emulated_legacy_status = {
    parity_err,
    timeout_flag,
    mouse_byte_flag,
    kbd_not_inhibited,
    cmd_data_flag,
    sys_flag,
    in_buf_loaded,
    out_buf_loaded
  };

  // Data bytes.

  // Every byte software writes to either legacy port while emulation is on lands in the input byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emulated_input_byte_q <= `LKE_RST_BYTE;
    end else if (ce && (evt.wr_data || evt.wr_cmd)) begin
      emulated_input_byte_q <= evt.byte_val;
    end
  end

  // The output byte is filled by the emulation software over APB.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emulated_output_byte_q <= `LKE_RST_BYTE;
    end else if (ce && wr_output) begin
      emulated_output_byte_q <= pwdata[7:0];
    end
  end

  // Legacy read data is latched per read, so it holds between accesses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_rdata <= `LKE_RST_BYTE;
    end else if (ce) begin
      if (evt.rd_data) begin
        io_rdata <= emulated_output_byte_q;
      end else if (evt.rd_cmd) begin
        io_rdata <= emulated_legacy_status;
      end
    end
  end

  // Interrupts.

  // Static decode of the emulation interrupt condition.
  // The external path is independent of the emulation enable by design.
  assign emul_cond = (legacy_emul_on &
                      (in_buf_loaded |
                       (~out_buf_loaded & char_wait_flag))) |
                     (ext_irq_en & (irq1_seen | irq12_seen));

  // Interrupt outputs are registered, so they lag their cause by one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq1     <= 1'b0;
      irq12    <= 1'b0;
      emul_irq <= 1'b0;
    end else if (ce) begin
      irq1     <= legacy_emul_on & legacy_irq_gate &
                  out_buf_loaded & ~mouse_byte_flag;
      irq12    <= legacy_emul_on & legacy_irq_gate &
                  out_buf_loaded & mouse_byte_flag;
      emul_irq <= emul_cond;
    end
  end

  // APB read path.

  // Full control word as software sees it; unused upper bits read zero.
  always_comb begin
    emulation_control_reg                     = `LKE_RST_WORD;
    emulation_control_reg[`LKE_CT_A20STATE]   = a20_state_in;
    emulation_control_reg[`LKE_CT_IRQ12ACT]   = irq12_seen;
    emulation_control_reg[`LKE_CT_IRQ1ACT]    = irq1_seen;
    emulation_control_reg[`LKE_CT_A20SEQ]     = a20_seq_active;
    emulation_control_reg[`LKE_CT_EXTEN]      = ext_irq_en;
    emulation_control_reg[`LKE_CT_IRQGATE]    = legacy_irq_gate;
    emulation_control_reg[`LKE_CT_CHARWAIT]   = char_wait_flag;
    emulation_control_reg[`LKE_CT_EMULIRQ]    = emul_cond;
    emulation_control_reg[`LKE_CT_EMULON]     = legacy_emul_on;
  end

  // Read multiplexer; byte registers sit in the low lane.
  always_comb begin
    rd_mux = `LKE_RST_WORD;
    case (paddr)
      `LKE_OFF_CTRL: begin
        rd_mux = emulation_control_reg;
      end
      `LKE_OFF_INPUT: begin
        rd_mux = {24'h00_0000, emulated_input_byte_q};
      end
      `LKE_OFF_OUTPUT: begin
        rd_mux = {24'h00_0000, emulated_output_byte_q};
      end
      `LKE_OFF_STATUS: begin
        rd_mux = {24'h00_0000, emulated_legacy_status};
      end
      default: begin
        rd_mux = `LKE_RST_WORD;
      end
    endcase
  end

  // Ready rises for exactly the access phase, giving one wait-free access.
  // Read data is sampled in the setup cycle, so a read sees the state of then.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= `LKE_RST_WORD;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= apb_setup;
      if (apb_setup) begin
        prdata  <= pwrite ? `LKE_RST_WORD : rd_mux;
        pslverr <= ~addr_hit;
      end else if (apb_done) begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ===== tb/lke_emul_props.sv
`timescale 1ns/10ps
`default_nettype none

`include "lke_map.svh"

// Port-side checker for the legacy emulation block.
module lke_emul_props
  import lke_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire lke_io_req_t io_req,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        irq1,
  input  wire logic        irq12,
  input  wire logic        emul_irq
);
  logic [4:0] ctl_q;
  logic       mapped;
  logic       io_hit;
  logic       st_wr;

  // Shadow of the low control bits, so the checker knows when emulation is on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 5'h00;
    end else if (ce && psel && penable && pready && pwrite && paddr == `LKE_OFF_CTRL) begin
      ctl_q <= pwdata[4:0];
    end
  end

  // A status write races a port read, so irq checks skip that case.
  assign io_hit = io_req.valid && (io_req.addr == `LKE_PORT_DATA || io_req.addr == `LKE_PORT_CMD);
  assign mapped = paddr inside {`LKE_OFF_CTRL, `LKE_OFF_INPUT, `LKE_OFF_OUTPUT, `LKE_OFF_STATUS};
  assign st_wr  = psel && penable && pwrite && paddr == `LKE_OFF_STATUS;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rdy_next;
    psel && !penable && ce |=> pready;
  endproperty
  a_rdy_next: assert property (p_rdy_next) else $error("pready late");
  property p_rdy_one;
    pready && ce |=> !pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready too long");
  property p_err;
    pready |-> (pslverr == !mapped);
  endproperty
  a_err: assert property (p_err) else $error("pslverr wrong");
  property p_err_only;
    pslverr |-> pready;
  endproperty
  a_err_only: assert property (p_err_only) else $error("pslverr alone");
  property p_rd_hold;
    ce && !(io_hit && !io_req.write) |=> $stable(io_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("io_rdata moved");
  property p_irq_excl;
    !(irq1 && irq12);
  endproperty
  a_irq_excl: assert property (p_irq_excl) else $error("both irqs");
  property p_irq_drop;
    ce && ctl_q[0] && io_hit && !io_req.write && io_req.addr == `LKE_PORT_DATA && !st_wr
      |=> ##1 !irq1 && !irq12;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq kept after read");
  property p_emul_set;
    ce && ctl_q[0] && io_hit && io_req.write && io_req.addr == `LKE_PORT_CMD |=> ##1 emul_irq;
  endproperty
  a_emul_set: assert property (p_emul_set) else $error("emul_irq missing");
  property p_emul_off;
    !$past(ctl_q[0]) && !$past(ctl_q[4]) |-> !emul_irq;
  endproperty
  a_emul_off: assert property (p_emul_off) else $error("emul_irq while off");
endmodule

bind lke_emul_top lke_emul_props i_lke_emul_props (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .io_req(io_req), .io_rdata(io_rdata), .irq1(irq1), .irq12(irq12), .emul_irq(emul_irq)
);

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none

`include "lke_map.svh"

module tb
  import lke_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0;
  logic penable = 1'b0, pwrite = 1'b0, kbd = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, irq1, irq12, emul_irq;
  lke_io_req_t io_req = '0;
  logic [7:0] io_rdata;
  int num_errors = 0, checked = 0;

  lke_emul_top i_lke_emul_top (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io_req(io_req), .io_rdata(io_rdata), .kbd_not_inhibited(kbd),
    .a20_state_in(1'b0), .kbc_irq1(1'b0), .kbc_irq12(1'b0), .irq1(irq1), .irq12(irq12),
    .emul_irq(emul_irq)
  );

  // Half period of 50 ns gives the 10 MHz bus clock.
  always #50 pclk = ~pclk;

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high at an edge.
  // Only the watchdog ends a wait for pready.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, r);
  endtask

  // One-cycle legacy port access; returns mid-cycle once its effects have landed.
  task io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    io_req <= '{valid: 1'b1, write: w, addr: a, data: d};
    @(posedge pclk);
    io_req <= '0;
    @(negedge pclk);
  endtask

  // Irq outputs trail their cause by one cycle, so two edges are enough.
  task w2();
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask

  task t_reset();
    rd(`LKE_OFF_STATUS, 32'h10, "status");
    kbd <= 1'b0;
    rd(`LKE_OFF_STATUS, 32'h00, "status");
    kbd <= 1'b1;
    rd(`LKE_OFF_OUTPUT, 32'h00, "output");
    rd(12'h200, 32'h00, "unmapped");
    chk("slverr", 32'h1, {31'h0, e});
    $display("test reset done");
  endtask

  task t_flags();
    apb(1'b1, `LKE_OFF_STATUS, 32'hc4);
    rd(`LKE_OFF_STATUS, 32'hd4, "status");
    apb(1'b1, `LKE_OFF_STATUS, 32'h00);
    rd(`LKE_OFF_STATUS, 32'h10, "status");
    io(1'b1, `LKE_PORT_CMD, 8'h12);
    rd(`LKE_OFF_STATUS, 32'h10, "status");
    rd(`LKE_OFF_INPUT, 32'h00, "input");
    chk("emul_irq", 32'h0, {31'h0, emul_irq});
    $display("test flags done");
  endtask

  task t_port_wr();
    apb(1'b1, `LKE_OFF_CTRL, 32'h1);
    io(1'b1, `LKE_PORT_DATA, 8'h5a);
    rd(`LKE_OFF_STATUS, 32'h12, "status");
    rd(`LKE_OFF_INPUT, 32'h5a, "input");
    chk("emul_irq", 32'h1, {31'h0, emul_irq});
    io(1'b1, `LKE_PORT_CMD, 8'h33);
    rd(`LKE_OFF_STATUS, 32'h1a, "status");
    apb(1'b1, `LKE_OFF_STATUS, 32'h00);
    w2();
    chk("emul_irq", 32'h0, {31'h0, emul_irq});
    $display("test port write done");
  endtask

  task t_a20();
    io(1'b1, `LKE_PORT_CMD, 8'hd1);
    apb(1'b0, `LKE_OFF_CTRL, 32'h0);
    chk("a20 seq", 32'h20, r & 32'h20);
    apb(1'b1, `LKE_OFF_STATUS, 32'h08);
    io(1'b1, `LKE_PORT_DATA, 8'h55);
    rd(`LKE_OFF_STATUS, 32'h10, "status");
    rd(`LKE_OFF_INPUT, 32'h55, "input");
    io(1'b1, `LKE_PORT_CMD, 8'h00);
    apb(1'b0, `LKE_OFF_CTRL, 32'h0);
    chk("a20 seq", 32'h00, r & 32'h20);
    apb(1'b1, `LKE_OFF_STATUS, 32'h00);
    $display("test gate a20 done");
  endtask

  task t_output();
    apb(1'b1, `LKE_OFF_OUTPUT, 32'ha7);
    apb(1'b1, `LKE_OFF_STATUS, 32'h01);
    apb(1'b1, `LKE_OFF_CTRL, 32'h9);
    w2();
    chk("irq1", 32'h1, {31'h0, irq1});
    chk("irq12", 32'h0, {31'h0, irq12});
    io(1'b0, `LKE_PORT_DATA, 8'h00);
    chk("io_rdata", 32'ha7, {24'h0, io_rdata});
    rd(`LKE_OFF_STATUS, 32'h10, "status");
    chk("irq1", 32'h0, {31'h0, irq1});
    apb(1'b1, `LKE_OFF_STATUS, 32'h21);
    w2();
    chk("irq12", 32'h1, {31'h0, irq12});
    chk("irq1", 32'h0, {31'h0, irq1});
    io(1'b0, `LKE_PORT_DATA, 8'h00);
    w2();
    chk("irq12", 32'h0, {31'h0, irq12});
    $display("test output done");
  endtask

  task t_charpend();
    apb(1'b1, `LKE_OFF_STATUS, 32'h00);
    apb(1'b1, `LKE_OFF_CTRL, 32'h5);
    w2();
    chk("emul_irq", 32'h1, {31'h0, emul_irq});
    apb(1'b1, `LKE_OFF_STATUS, 32'h01);
    w2();
    chk("emul_irq", 32'h0, {31'h0, emul_irq});
    apb(1'b1, `LKE_OFF_STATUS, 32'h00);
    apb(1'b1, `LKE_OFF_CTRL, 32'h4);
    w2();
    chk("emul_irq", 32'h0, {31'h0, emul_irq});
    $display("test char pending done");
  endtask

  // With the clock enable low a port write must leave no trace at all.
  task t_freeze();
    apb(1'b1, `LKE_OFF_CTRL, 32'h1);
    ce <= 1'b0;
    io(1'b1, `LKE_PORT_DATA, 8'h66);
    @(posedge pclk);
    ce <= 1'b1;
    rd(`LKE_OFF_STATUS, 32'h10, "status");
    rd(`LKE_OFF_INPUT, 32'h00, "input");
    apb(1'b1, `LKE_OFF_CTRL, 32'h0);
    $display("test clock enable done");
  endtask

  task complete_run();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence after six cycles of reset.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_flags();
    t_port_wr();
    t_a20();
    t_output();
    t_charpend();
    t_freeze();
    complete_run();
  end

  // The tests need under two hundred cycles; three thousand means a hang.
  initial begin
    #300000;
    num_errors++;
    $display("watchdog expired");
    complete_run();
  end
endmodule

`default_nettype wire
